// ===== inc/dmem_pkg.sv
// Package for the data-memory address decoder: register map, fields, types.
// Assumes a single 200 MHz clock domain shared by core and decoder.
package dmem_pkg;
	localparam logic [7:0]  AUX_MEMORY_CONTROL_OFS     = 8'h8E;
	localparam logic [7:0]  POINTER_SELECT_CONTROL_OFS = 8'hA2;
	localparam logic [7:0]  DATA_POINTER_ZERO_LOW_OFS          = 8'h82;
	localparam logic [7:0]  DATA_POINTER_ZERO_HIGH_OFS         = 8'h83;
	localparam logic [7:0]  DATA_POINTER_ONE_LOW_OFS           = 8'h84;
	localparam logic [7:0]  DATA_POINTER_ONE_HIGH_OFS          = 8'h85;
	localparam logic [7:0]  AUX_RESET                  = 8'h00;
	localparam logic [7:0]  PSEL_RESET                 = 8'h00;
	localparam int          LATCH_SUPPRESS_BIT         = 0;
	localparam int          XRAM_BYPASS_BIT            = 1;
	localparam int          POINTER_SELECT_BIT         = 0;
	localparam int          USER_FLAG_TWO_BIT          = 3;
	localparam logic [15:0] XRAM_LIMIT                 = 16'h0300;
	localparam int          XRAM_DEPTH                 = 768;
	localparam int          IRAM_DEPTH                 = 256;
	localparam int          SFR_BASE                   = 128;
	localparam int          CNT_ADDR_NS                = 5;
	localparam int          CLK_NS                     = 5;
	localparam int          CNT_ADDR                   = (CNT_ADDR_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		XM_IDLE  = 2'b00,
		XM_ADDR  = 2'b01,
		XM_DATA  = 2'b10,
		XM_DONE  = 2'b11
	} xmState_t;

	// Core request for one data-memory access
	typedef struct packed {
		logic        req;
		logic        wr;
		logic        indirect;
		logic        extMove;
		logic        usePointer;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} memReq_t;

	// External bus pin group
	typedef struct packed {
		logic [7:0] lowOut;
		logic       lowOe_n;
		logic [7:0] highAddr;
		logic       wr_n;
		logic       rd_n;
		logic       ale;
	} extBus_t;
endpackage : dmem_pkg

// ===== rtl/dmem_ram.sv
// Single-port synchronous RAM, one-cycle read latency.
// Assumes the caller gates the enable by its own clock enable.
`timescale 1ns/1ps
`default_nettype none
module dmem_ram #(
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	input  wire logic          clk,   // Clock
	input  wire logic          en,    // Access enable
	input  wire logic          we,    // Write enable
	input  wire logic [AW-1:0] addr,  // Word address
	input  wire logic [7:0]    wdata, // Write data
	output var  logic [7:0]    rdata  // Read data
);
	logic [7:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (en) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata <= mem[addr];
		end
	end
endmodule : dmem_ram
`default_nettype wire

// ===== rtl/data_memory_address_decode.sv
// Data-memory address decoder: internal RAM, special registers, expanded
// RAM and the multiplexed external bus. Assumes a core on ref_clk.
// Function
// - Locations 00H-7FH reachable directly and indirectly.
// - 80H-FFH: indirect reaches upper RAM, direct reaches special registers.
// - 768 bytes expanded RAM at 00H-2FFH while bypass bit is clear.
// - Bypass clear, pointer move below 0300H hits expanded RAM, no strobes.
// - Bypass clear, pointer move at 0300H or above runs an external cycle.
// - Bypass clear, register-indirect move hits expanded RAM 0-0FFH only.
// - Bypass set, every external move goes off chip with a strobe.
// - Register-indirect external move drives 8-bit address on low port.
// - Pointer external move: high byte on high port, low byte muxed low.
// - Active-low write and read strobes on port three pins 6 and 7.
// - External data space spans 64 kB.
// - Latch strobe free-runs at half rate unless suppressed, then only moves.
// - Stack pointer addresses only the 256 bytes of internal RAM.
// - Two 16-bit data pointers chosen by the pointer-select bit.
// - Pointer-select register bit 2 always reads 0.
// - Pointer-select register bit 3 is a free user flag.
// - Both control registers reset to 00H.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module data_memory_address_decode (
	input  wire logic             ref_clk,    // 200 MHz clock
	input  wire logic             rstn,       // Async reset, active low
	input  wire logic             clkEn,      // Freezes all state but the reset synchronizer when low
	input  wire dmem_pkg::memReq_t coreReq,   // Core access request
	input  wire logic             codeMove,   // Code-table move pulse
	input  wire logic             stackOp,    // Request is a stack access
	input  wire logic             pointerInc, // Increment selected pointer
	input  wire logic [7:0]       lowIn,      // Low port pin input
	output var  dmem_pkg::extBus_t busOut,    // External bus pins
	output var  logic [7:0]       rdData,     // Read data
	output var  logic             rdValid,    // Read data valid pulse
	output var  logic             busy,       // External cycle running
	input  wire logic [7:0]       regAddr,    // Register address
	input  wire logic [7:0]       regWdata,   // Register write data
	input  wire logic             regWr,      // Register write strobe
	input  wire logic             regRd,      // Register read strobe
	output var  logic [7:0]       regRdata    // Register read data
);
	import dmem_pkg::*;

	logic        rstMeta_ff, rstSync_ff;
	logic [7:0]  lowMeta_ff, lowSync_ff;
	logic [7:0]  aux_ff, nxt_aux;
	logic [7:0]  psel_ff, nxt_psel;
	logic [15:0] data_pointer_zero_ff, nxt_data_pointer_zero, data_pointer_one_ff, nxt_data_pointer_one;
	logic [7:0]  sfrScratch_ff [SFR_BASE];
	logic [7:0]  regRdata_ff, nxt_regRdata;
	xmState_t    st_ff, nxt_st;
	logic        wrLatch_ff, nxt_wrLatch;
	logic [7:0]  wdLatch_ff, nxt_wdLatch;
	extBus_t     bus_ff, nxt_bus;
	logic        aleTick_ff;
	logic [7:0]  rd_ff, nxt_rd;
	logic        rdv_ff, nxt_rdv;
	logic        iramSel_ff, xramSel_ff, sfrSel_ff;
	logic [7:0]  iramQ, xramQ;
	logic [15:0] curPtr, xAddr;
	logic        isInt, toXram, toExt, sfrHit;
	logic [9:0]  xramAddr;
	logic        capRd_ff, nxt_capRd, busy_ff, nxt_busy;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rstMeta_ff <= 1'b0;
			rstSync_ff <= 1'b0;
		end else begin
			rstMeta_ff <= 1'b1;
			rstSync_ff <= rstMeta_ff;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (clkEn) begin
			lowMeta_ff <= lowIn;
			lowSync_ff <= lowMeta_ff;
		end
	end

	// Pointer selection and routing decode
	always_comb begin
		curPtr = psel_ff[POINTER_SELECT_BIT] ? data_pointer_one_ff : data_pointer_zero_ff;
		xAddr  = coreReq.usePointer ? curPtr : {8'h00, coreReq.addr};
		isInt  = coreReq.req && !coreReq.extMove;
		// Stack and low half always RAM; upper half by addressing mode
		sfrHit = isInt && !stackOp && !coreReq.indirect && coreReq.addr[7];
		toXram = coreReq.req && coreReq.extMove && !aux_ff[XRAM_BYPASS_BIT]
			&& (!coreReq.usePointer || xAddr < XRAM_LIMIT);
		toExt  = coreReq.req && coreReq.extMove && !toXram;
		xramAddr = xAddr[9:0];
	end

	dmem_ram #(.DEPTH(IRAM_DEPTH), .AW(8)) iram (
		.clk   (ref_clk),
		.en    (clkEn && isInt && !sfrHit),
		.we    (coreReq.wr),
		.addr  (coreReq.addr),
		.wdata (coreReq.wdata),
		.rdata (iramQ)
	);

	dmem_ram #(.DEPTH(XRAM_DEPTH), .AW(10)) xram (
		.clk   (ref_clk),
		.en    (clkEn && toXram),
		.we    (coreReq.wr),
		.addr  (xramAddr),
		.wdata (coreReq.wdata),
		.rdata (xramQ)
	);

	// Control registers and data pointers
	always_comb begin
		nxt_aux   = aux_ff;
		nxt_psel  = psel_ff;
		nxt_data_pointer_zero = data_pointer_zero_ff;
		nxt_data_pointer_one = data_pointer_one_ff;
		nxt_regRdata = 8'h00;
		if (regWr) begin
			if (regAddr == AUX_MEMORY_CONTROL_OFS) begin
				nxt_aux = {6'h00, regWdata[1:0]};
			end else if (regAddr == POINTER_SELECT_CONTROL_OFS) begin
				nxt_psel = {4'h0, regWdata[3], 1'b0, 1'b0, regWdata[0]};
			end else if (regAddr == DATA_POINTER_ZERO_LOW_OFS) begin
				nxt_data_pointer_zero[7:0] = regWdata;
			end else if (regAddr == DATA_POINTER_ZERO_HIGH_OFS) begin
				nxt_data_pointer_zero[15:8] = regWdata;
			end else if (regAddr == DATA_POINTER_ONE_LOW_OFS) begin
				nxt_data_pointer_one[7:0] = regWdata;
			end else if (regAddr == DATA_POINTER_ONE_HIGH_OFS) begin
				nxt_data_pointer_one[15:8] = regWdata;
			end
		end else if (pointerInc) begin
			if (psel_ff[POINTER_SELECT_BIT]) begin
				nxt_data_pointer_one = data_pointer_one_ff + 16'h0001;
			end else begin
				nxt_data_pointer_zero = data_pointer_zero_ff + 16'h0001;
			end
		end
		if (regRd) begin
			if (regAddr == AUX_MEMORY_CONTROL_OFS) begin
				nxt_regRdata = aux_ff;
			end else if (regAddr == POINTER_SELECT_CONTROL_OFS) begin
				nxt_regRdata = psel_ff;
			end else if (regAddr == DATA_POINTER_ZERO_LOW_OFS) begin
				nxt_regRdata = data_pointer_zero_ff[7:0];
			end else if (regAddr == DATA_POINTER_ZERO_HIGH_OFS) begin
				nxt_regRdata = data_pointer_zero_ff[15:8];
			end else if (regAddr == DATA_POINTER_ONE_LOW_OFS) begin
				nxt_regRdata = data_pointer_one_ff[7:0];
			end else if (regAddr == DATA_POINTER_ONE_HIGH_OFS) begin
				nxt_regRdata = data_pointer_one_ff[15:8];
			end else begin
				nxt_regRdata = 8'h00;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			aux_ff      <= AUX_RESET;
			psel_ff     <= PSEL_RESET;
			data_pointer_zero_ff    <= 16'h0000;
			data_pointer_one_ff    <= 16'h0000;
			regRdata_ff <= 8'h00;
		end else if (clkEn) begin
			aux_ff      <= nxt_aux;
			psel_ff     <= nxt_psel;
			data_pointer_zero_ff    <= nxt_data_pointer_zero;
			data_pointer_one_ff    <= nxt_data_pointer_one;
			regRdata_ff <= nxt_regRdata;
		end
	end

	// Core-side direct special-register scratch space for unmapped SFRs
	always_ff @(posedge ref_clk) begin
		if (clkEn && sfrHit && coreReq.wr) begin
			sfrScratch_ff[coreReq.addr[6:0]] <= coreReq.wdata;
		end
	end

	// External bus cycle sequencer
	always_comb begin
		nxt_st      = st_ff;
		nxt_wrLatch = wrLatch_ff;
		nxt_wdLatch = wdLatch_ff;
		nxt_bus     = bus_ff;
		nxt_rd      = rd_ff;
		nxt_rdv     = 1'b0;
		nxt_capRd   = 1'b0;
		nxt_bus.ale = aux_ff[LATCH_SUPPRESS_BIT] ? 1'b0 : aleTick_ff;
		nxt_bus.wr_n = 1'b1;
		nxt_bus.rd_n = 1'b1;
		if (aux_ff[LATCH_SUPPRESS_BIT] && codeMove) begin
			nxt_bus.ale = 1'b1;
		end
		case (st_ff)
			XM_IDLE: begin
				nxt_bus.lowOe_n = 1'b1;
				if (toExt) begin
					nxt_st      = XM_ADDR;
					nxt_wrLatch = coreReq.wr;
					nxt_wdLatch = coreReq.wdata;
					nxt_bus.lowOut  = xAddr[7:0];
					nxt_bus.lowOe_n = 1'b0;
					if (coreReq.usePointer) begin
						nxt_bus.highAddr = xAddr[15:8];
					end
					nxt_bus.ale = 1'b1;
				end
			end
			XM_ADDR: begin
				nxt_st = XM_DATA;
				nxt_bus.ale = 1'b0;
				if (wrLatch_ff) begin
					nxt_bus.lowOut  = wdLatch_ff;
					nxt_bus.lowOe_n = 1'b0;
					nxt_bus.wr_n    = 1'b0;
				end else begin
					nxt_bus.lowOe_n = 1'b1;
					nxt_bus.rd_n    = 1'b0;
				end
			end
			XM_DATA: begin
				nxt_st = XM_DONE;
				nxt_bus.ale = 1'b0;
				if (wrLatch_ff) begin
					nxt_bus.wr_n = 1'b0;
				end else begin
					nxt_bus.rd_n = 1'b0;
				end
			end
			XM_DONE: begin
				nxt_st = XM_IDLE;
				nxt_bus.lowOe_n = 1'b1;
				// Pin data needs both sync stages, capture next cycle
				nxt_capRd = !wrLatch_ff;
			end
			default: nxt_st = XM_IDLE;
		endcase
		nxt_busy = (nxt_st != XM_IDLE);
		if (capRd_ff) begin
			nxt_rd  = lowSync_ff;
			nxt_rdv = 1'b1;
		end else if (iramSel_ff) begin
			nxt_rd  = iramQ;
			nxt_rdv = 1'b1;
		end else if (xramSel_ff) begin
			nxt_rd  = xramQ;
			nxt_rdv = 1'b1;
		end else if (sfrSel_ff) begin
			nxt_rd  = 8'h00;
			nxt_rdv = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSync_ff) begin
		if (!rstSync_ff) begin
			st_ff       <= XM_IDLE;
			wrLatch_ff  <= 1'b0;
			wdLatch_ff  <= 8'h00;
			bus_ff      <= '{lowOut: 8'h00, lowOe_n: 1'b1, highAddr: 8'h00,
				wr_n: 1'b1, rd_n: 1'b1, ale: 1'b0};
			aleTick_ff  <= 1'b0;
			rd_ff       <= 8'h00;
			rdv_ff      <= 1'b0;
			iramSel_ff  <= 1'b0;
			xramSel_ff  <= 1'b0;
			sfrSel_ff   <= 1'b0;
			capRd_ff    <= 1'b0;
			busy_ff     <= 1'b0;
		end else if (clkEn) begin
			st_ff       <= nxt_st;
			wrLatch_ff  <= nxt_wrLatch;
			wdLatch_ff  <= nxt_wdLatch;
			bus_ff      <= nxt_bus;
			aleTick_ff  <= !aleTick_ff;
			rd_ff       <= nxt_rd;
			rdv_ff      <= nxt_rdv;
			iramSel_ff  <= isInt && !sfrHit && !coreReq.wr;
			xramSel_ff  <= toXram && !coreReq.wr;
			sfrSel_ff   <= sfrHit && !coreReq.wr;
			capRd_ff    <= nxt_capRd;
			busy_ff     <= nxt_busy;
		end
	end

	always_comb begin
		busOut   = bus_ff;
		rdData   = rd_ff;
		rdValid  = rdv_ff;
		busy     = busy_ff;
		regRdata = regRdata_ff;
	end
endmodule : data_memory_address_decode
`default_nettype wire

// ===== verif/data_memory_address_decode_asserts.sv
// Port checker for the data-memory decoder.
// Assumes binding into data_memory_address_decode on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module data_memory_address_decode_asserts (
	input wire logic              ref_clk,  // Clock
	input wire logic              rstn,     // Reset, active low
	input wire logic              clkEn,    // Clock enable
	input wire dmem_pkg::memReq_t coreReq,  // Core request
	input wire dmem_pkg::extBus_t busOut,   // Bus pins
	input wire logic              rdValid,  // Read valid
	input wire logic              busy,     // Bus cycle running
	input wire logic [7:0]        regAddr,  // Register address
	input wire logic [7:0]        regWdata, // Register write data
	input wire logic              regWr,    // Register write
	input wire logic              regRd,    // Register read
	input wire logic [7:0]        regRdata  // Register read data
);
	import dmem_pkg::*;
	logic       aoFf;
	logic       bypassFf;
	logic [2:0] upCnt;
	// Shadow of the aux control bits, settle counter after reset
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			aoFf <= 1'b0;
			bypassFf <= 1'b0;
			upCnt <= 3'h0;
		end else begin
			if (regWr && clkEn && regAddr == AUX_MEMORY_CONTROL_OFS) begin
				aoFf <= regWdata[LATCH_SUPPRESS_BIT];
				bypassFf <= regWdata[XRAM_BYPASS_BIT];
			end
			if (upCnt != 3'h7)
				upCnt <= upCnt + 3'h1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	property p_strobe_one; busOut.wr_n || busOut.rd_n; endproperty
	a_strobe_one: assert property (p_strobe_one) else $error("both strobes low");
	property p_ale_lead; $fell(busOut.wr_n) || $fell(busOut.rd_n) |-> $past(busOut.ale); endproperty
	a_ale_lead: assert property (p_ale_lead) else $error("strobe without latch");
	property p_psel_bit2; regRd && regAddr == POINTER_SELECT_CONTROL_OFS
		|=> !regRdata[2]; endproperty
	a_psel_bit2: assert property (p_psel_bit2) else $error("select bit2 set");
	property p_user_flag; regWr && regAddr == POINTER_SELECT_CONTROL_OFS
		##2 regRd && regAddr == POINTER_SELECT_CONTROL_OFS
		|=> regRdata[3] == $past(regWdata[3], 3); endproperty
	a_user_flag: assert property (p_user_flag) else $error("user flag lost");
	property p_int_read; coreReq.req && !coreReq.wr
		&& (!coreReq.extMove || (!bypassFf && !coreReq.usePointer)) |-> ##2 rdValid; endproperty
	a_int_read: assert property (p_int_read) else $error("internal read late");
	property p_xram_quiet; coreReq.req && coreReq.extMove && !coreReq.usePointer && !bypassFf
		|-> ##1 (busOut.wr_n && busOut.rd_n)[*4]; endproperty
	a_xram_quiet: assert property (p_xram_quiet) else $error("strobe on xram hit");
	property p_bypass_go; coreReq.req && coreReq.extMove && bypassFf
		|-> ##[1:4] (!busOut.wr_n || !busOut.rd_n); endproperty
	a_bypass_go: assert property (p_bypass_go) else $error("bypass without strobe");
	property p_ext_seq; coreReq.req && coreReq.extMove && bypassFf
		|=> (busOut.ale && !busOut.lowOe_n && busy)
		##1 ((!busOut.wr_n || !busOut.rd_n) && busy)[*2]
		##1 (busOut.wr_n && busOut.rd_n && !busy); endproperty
	a_ext_seq: assert property (p_ext_seq) else $error("external cycle order wrong");
	property p_ale_run; upCnt == 3'h7 && !aoFf && !$past(aoFf) && !$past(aoFf, 2) && !busy
		&& !$past(busy) && !$past(busy, 2) |-> busOut.ale != $past(busOut.ale); endproperty
	a_ale_run: assert property (p_ale_run) else $error("latch strobe stalled");
endmodule : data_memory_address_decode_asserts
bind data_memory_address_decode data_memory_address_decode_asserts
	u_data_memory_address_decode_asserts (.ref_clk, .rstn, .clkEn, .coreReq, .busOut,
	.rdValid, .busy, .regAddr, .regWdata, .regWr, .regRd, .regRdata);
`default_nettype wire

// ===== verif/ext_mem_model.sv
// External data memory on the multiplexed bus.
// Assumes the address is latched while ale is high and the low port driven.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
	input  wire logic              ref_clk,  // Clock
	input  wire dmem_pkg::extBus_t bus,      // Bus pins
	output var  logic [7:0]        lowIn,    // Low port back to design
	output var  logic [15:0]       lastAddr  // Last latched address
);
	import dmem_pkg::*;
	logic [7:0] mem [0:65535];
	logic [7:0] held = 8'h00;
	logic       blk = 1'b0;
	initial lastAddr = 16'h0000;
	always @(posedge ref_clk) begin
		if (!blk && bus.ale && !bus.lowOe_n && bus.wr_n && bus.rd_n)
			lastAddr <= {bus.highAddr, bus.lowOut};
		if (!bus.wr_n)
			mem[lastAddr] <= bus.lowOut;
		if (!bus.rd_n)
			held <= mem[lastAddr];
		// No relatch on write data until the port is released
		blk <= (!bus.wr_n || !bus.rd_n) ? 1'b1 : (bus.lowOe_n ? 1'b0 : blk);
	end
	// Released port shows the inverted last value
	always_comb lowIn = !bus.rd_n ? mem[lastAddr] : ~held;
endmodule : ext_mem_model
`default_nettype wire

// ===== verif/data_memory_address_decode_tb_top.sv
// Self-checking bench for the data-memory decoder.
// Assumes the external memory model on the bus and ref_clk at 200 MHz.
`timescale 1ns/1ps
`default_nettype none
module data_memory_address_decode_tb_top;
	import dmem_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rstn = 1'b0;
	memReq_t     coreReq = '0;
	logic        codeMove = 1'b0;
	logic        stackOp = 1'b0;
	logic        pointerInc = 1'b0;
	logic [7:0]  regAddr = 8'h00;
	logic [7:0]  regWdata = 8'h00;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [7:0]  lowIn, rdData, regRdata, r;
	extBus_t     busOut;
	logic        rdValid, busy, strb;
	logic        byp = 1'b0;
	logic        psel = 1'b0;
	logic [15:0] lastAddr;
	logic [31:0] seed = 32'h3cf0_a48d;
	int          miscompares = 0;
	int          total_checks = 0;
	int          stepNo = 0;
	int          n;
	always #2.5 ref_clk = ~ref_clk;
	data_memory_address_decode u_data_memory_address_decode (.ref_clk, .rstn, .clkEn(1'b1),
		.coreReq, .codeMove, .stackOp, .pointerInc, .lowIn, .busOut, .rdData, .rdValid,
		.busy, .regAddr, .regWdata, .regWr, .regRd, .regRdata);
	ext_mem_model u_ext_mem_model (.ref_clk, .bus(busOut), .lowIn, .lastAddr);
	always @(posedge ref_clk) if (busOut.wr_n === 1'b0 || busOut.rd_n === 1'b0) strb = 1'b1;
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function logic expExt(input logic b, p, input logic [15:0] a);
		return b || (p && a >= 16'h0300);
	endfunction : expExt
	task chk(input logic [15:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task step;
		stepNo++;
		$display("test %0d done", stepNo);
	endtask : step
	task regW(input logic [7:0] a, d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
		if (a == 8'h8E) byp = d[1];
		if (a == 8'hA2) psel = d[0];
	endtask : regW
	task regR(input logic [7:0] a);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 r = regRdata;
	endtask : regR
	task req(input logic w, ind, ext, ptr, stk, input logic [7:0] a, d);
		@(posedge ref_clk);
		strb = 1'b0;
		r = 'x;
		coreReq <= {1'b1, w, ind, ext, ptr, a, d};
		stackOp <= stk;
		@(posedge ref_clk);
		coreReq.req <= 1'b0;
		stackOp <= 1'b0;
		repeat (9) begin
			@(posedge ref_clk);
			#1 if (rdValid === 1'b1) r = rdData;
		end
	endtask : req
	task xm(input logic ptr, input logic [15:0] a, input logic [7:0] d);
		logic e;
		e = expExt(byp, ptr, a);
		if (ptr) begin
			regW(psel ? 8'h84 : 8'h82, a[7:0]);
			regW(psel ? 8'h85 : 8'h83, a[15:8]);
		end
		req(1, 1, 1, ptr, 0, a[7:0], d);
		chk(16'(strb), 16'(e));
		if (e) chk(ptr ? lastAddr : {8'h00, lastAddr[7:0]}, ptr ? a : {8'h00, a[7:0]});
		req(0, 1, 1, ptr, 0, a[7:0], 8'h00);
		chk(16'(strb), 16'(e));
		chk(16'(r), 16'(d));
	endtask : xm
	task aleCnt;
		n = 0;
		repeat (2) @(posedge ref_clk);
		repeat (10) begin
			@(posedge ref_clk);
			#1 n += int'(busOut.ale);
		end
	endtask : aleCnt
	task close_out;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	initial begin
		#200000;
		miscompares++;
		close_out;
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		regR(8'h8E);
		chk(16'(r), 16'h0000);
		regR(8'hA2);
		chk(16'(r), 16'h0000);
		regW(8'hA2, 8'h0D);
		regR(8'hA2);
		chk(16'(r), 16'h0009);
		regW(8'h90, 8'h55);
		regR(8'h90);
		chk(16'(r), 16'h0000);
		regW(8'hA2, 8'h00);
		step;
		req(1, 0, 0, 0, 0, 8'h20, 8'h3C);
		req(0, 1, 0, 0, 0, 8'h20, 8'h00);
		chk(16'(r), 16'h003C);
		req(1, 1, 0, 0, 0, 8'h90, 8'hA7);
		req(1, 0, 0, 0, 1, 8'h91, 8'h6E);
		req(0, 0, 0, 0, 0, 8'h90, 8'h00);
		chk(16'(r), 16'h0000);
		req(0, 1, 0, 0, 0, 8'h90, 8'h00);
		chk(16'(r), 16'h00A7);
		req(0, 1, 0, 0, 0, 8'h91, 8'h00);
		chk(16'(r), 16'h006E);
		step;
		xm(1, 16'h02FF, 8'h11);
		xm(1, 16'h0300, 8'h22);
		xm(0, 16'h00A5, 8'h33);
		regW(8'hA2, 8'h01);
		xm(1, 16'h4567, 8'h44);
		@(posedge ref_clk) pointerInc <= 1'b1;
		@(posedge ref_clk) pointerInc <= 1'b0;
		req(1, 1, 1, 1, 0, 8'h00, 8'h55);
		chk(lastAddr, 16'h4568);
		regW(8'h8E, 8'h02);
		xm(0, 16'h00A5, 8'h66);
		xm(1, 16'h0123, 8'h77);
		step;
		regW(8'h8E, 8'h01);
		aleCnt;
		chk(16'(n), 16'h0000);
		@(posedge ref_clk) codeMove <= 1'b1;
		@(posedge ref_clk) codeMove <= 1'b0;
		#1 chk(16'(busOut.ale), 16'h0001);
		regW(8'h8E, 8'h00);
		aleCnt;
		chk(16'(n), 16'h0005);
		step;
		repeat (8) begin
			seed = lfsr(seed);
			regW(8'h8E, {6'h00, seed[24], 1'b0});
			xm(1, seed[15:0], seed[23:16]);
		end
		step;
		close_out;
	end
endmodule : data_memory_address_decode_tb_top
`default_nettype wire
